// >>> hdl/bridge_pkg.sv
// Package: register map, field positions, reset values and routing types of the window bridge
package bridge_pkg;
    // Printed offsets are not all multiples of four: they are indices, byte address = 4 * index
    localparam logic [7:0] IDX_PREFETCH_WINDOW_BASE = 8'h24;
    localparam logic [7:0] IDX_PREFETCH_WINDOW_LIMIT = 8'h26;
    localparam logic [7:0] IDX_BRIDGE_CONTROL = 8'h3e;
    // Registers of our own for the loose control and status bits
    localparam logic [7:0] IDX_ROUTE_CONFIG = 8'h40;
    localparam logic [7:0] IDX_DECODE_STATUS = 8'h41;
    localparam int ADDR_W = 10;
    localparam logic [15:0] RST_PREFETCH_BASE = 16'hfff0;
    localparam logic [15:0] RST_PREFETCH_LIMIT = 16'h0000;
    localparam logic [7:0] RST_BRIDGE_CONTROL = 8'h00;
    localparam logic [11:0] RST_BASE_FIELD = 12'hfff;
    localparam logic [11:0] RST_LIMIT_FIELD = 12'h000;
    localparam int FIELD_LSB = 4;
    localparam logic [19:0] LOW_ZERO = 20'h0_0000;
    localparam logic [19:0] LOW_ONES = 20'hf_ffff;
    // Bridge control bit positions
    localparam int BC_PARITY_RESP = 0;
    localparam int BC_SERR_FWD = 1;
    localparam int BC_ISA_ALIAS = 2;
    localparam int BC_LEGACY_VIDEO = 3;
    localparam int BC_ABORT_MODE = 5;
    localparam int BC_SEC_RESET = 6;
    localparam int BC_BACK_TO_BACK = 7;
    localparam logic [7:0] BC_WRITABLE = 8'h0d;
    // Route configuration bit positions
    localparam int RC_MONO = 0;
    localparam int RC_GLOBAL_ERR = 1;
    localparam logic [31:0] ALL_ONES = 32'hffff_ffff;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // 256-byte units in the low 10 I/O address bits: first 256 of a 1-KB block is not alias
    localparam logic [1:0] IO_KB_LOW = 2'b00;
    typedef enum logic [1:0] {ROUTE_NONE, ROUTE_SECONDARY, ROUTE_HUB} route_t;
endpackage

// >>> hdl/window_cfg_if.sv
// Interface: decoded configuration fields passed from the register file to the decoder
`timescale 1ns/1ps
interface window_cfg_if;
    logic [11:0] prefetch_base_field;
    logic [11:0] prefetch_limit_field;
    logic legacy_video_enable;
    logic mono_display_routing_bit;
    logic isa_alias_enable;
    logic [15:0] io_window_base;
    logic [15:0] io_window_limit;
    modport regs (output prefetch_base_field, prefetch_limit_field, legacy_video_enable,
        mono_display_routing_bit, isa_alias_enable, io_window_base, io_window_limit);
    modport dec (input prefetch_base_field, prefetch_limit_field, legacy_video_enable,
        mono_display_routing_bit, isa_alias_enable, io_window_base, io_window_limit);
endinterface

// >>> hdl/window_decode.sv
// Combinational route decode of processor memory and I/O requests
`timescale 1ns/1ps
module window_decode (
    window_cfg_if.dec cfg,
    // Memory request
    input wire logic [31:0] mem_addr,
    input wire logic mem_is_legacy_color,
    input wire logic mem_is_legacy_mono,
    // I/O request
    input wire logic [15:0] io_addr,
    output bridge_pkg::route_t mem_route,
    output bridge_pkg::route_t io_route,
    output logic prefetch_hit
);
    logic [31:0] base_full;
    logic [31:0] limit_full;
    logic io_in_range;
    logic io_alias;
    assign base_full = {cfg.prefetch_base_field, bridge_pkg::LOW_ZERO};
    assign limit_full = {cfg.prefetch_limit_field, bridge_pkg::LOW_ONES};
    // Reset base above reset limit makes this empty until programmed
    assign prefetch_hit = (mem_addr >= base_full) && (mem_addr <= limit_full);
    assign io_in_range = (io_addr >= cfg.io_window_base) && (io_addr <= cfg.io_window_limit);
    assign io_alias = cfg.isa_alias_enable && (io_addr[9:8] != bridge_pkg::IO_KB_LOW);
    always_comb begin
        // Mono always goes to hub; colour only to secondary with video enabled
        if (mem_is_legacy_mono) begin
            mem_route = bridge_pkg::ROUTE_HUB;
        end else if (mem_is_legacy_color) begin
            mem_route = cfg.legacy_video_enable ? bridge_pkg::ROUTE_SECONDARY
                : bridge_pkg::ROUTE_HUB;
        end else if (prefetch_hit) begin
            mem_route = bridge_pkg::ROUTE_SECONDARY;
        end else begin
            mem_route = bridge_pkg::ROUTE_NONE;
        end
        if (!io_in_range) begin
            io_route = bridge_pkg::ROUTE_NONE;
        end else if (io_alias) begin
            io_route = bridge_pkg::ROUTE_HUB;
        end else begin
            io_route = bridge_pkg::ROUTE_SECONDARY;
        end
    end
endmodule

// >>> hdl/axi_regs.sv
// Register file for the prefetch window and bridge control, reached over AXI4-Lite
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
module axi_regs (
    input wire logic clk,
    input wire logic rst,
    window_cfg_if.regs cfg,
    // Write channels
    input wire logic [bridge_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // Read channels
    input wire logic [bridge_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Block state
    input wire logic [7:0] status_word,
    output logic parity_response_enable,
    output logic bridge_global_error_enable
);
    logic [bridge_pkg::ADDR_W-1:0] aw_q;
    logic [31:0] w_q;
    logic [3:0] ws_q;
    logic [11:0] base_q;
    logic [11:0] limit_q;
    logic [7:0] bc_q;
    logic [1:0] rc_q;
    logic [15:0] iob_q;
    logic [15:0] iol_q;
    logic do_write;
    logic [7:0] widx;
    logic [7:0] ridx;
    logic w_base;
    logic w_limit;
    logic w_bc;
    logic w_rc;
    logic w_iob;
    logic w_iol;
    logic w_ok;
    logic [31:0] rd_val;
    logic r_ok;
    // Ready low means the channel holds a word that has not yet been written
    assign do_write = !awready && !wready && !bvalid;
    assign widx = aw_q[9:2];
    assign ridx = araddr[9:2];
    assign w_base = do_write && widx == bridge_pkg::IDX_PREFETCH_WINDOW_BASE;
    assign w_limit = do_write && widx == bridge_pkg::IDX_PREFETCH_WINDOW_LIMIT;
    assign w_bc = do_write && widx == bridge_pkg::IDX_BRIDGE_CONTROL;
    assign w_rc = do_write && widx == bridge_pkg::IDX_ROUTE_CONFIG;
    // I/O window pair shares one word of our own: limit high, base low
    assign w_iob = do_write && widx == bridge_pkg::IDX_DECODE_STATUS + 8'h01;
    assign w_iol = w_iob;
    assign w_ok = w_base | w_limit | w_bc | w_rc | w_iob |
        (do_write && widx == bridge_pkg::IDX_DECODE_STATUS);
    // Hardwired zeros in low nibbles and bits 7:4,1 of control
    assign rd_val =
        (ridx == bridge_pkg::IDX_PREFETCH_WINDOW_BASE) ? {16'h0000, base_q, 4'h0} :
        (ridx == bridge_pkg::IDX_PREFETCH_WINDOW_LIMIT) ? {16'h0000, limit_q, 4'h0} :
        (ridx == bridge_pkg::IDX_BRIDGE_CONTROL) ? {24'h00_0000, bc_q} :
        (ridx == bridge_pkg::IDX_ROUTE_CONFIG) ? {30'h0000_0000, rc_q} :
        (ridx == bridge_pkg::IDX_DECODE_STATUS) ? {24'h00_0000, status_word} :
        (ridx == bridge_pkg::IDX_DECODE_STATUS + 8'h01) ? {iol_q, iob_q} : 32'h0000_0000;
    assign r_ok = (ridx == bridge_pkg::IDX_PREFETCH_WINDOW_BASE) ||
        (ridx == bridge_pkg::IDX_PREFETCH_WINDOW_LIMIT) ||
        (ridx == bridge_pkg::IDX_BRIDGE_CONTROL) || (ridx == bridge_pkg::IDX_ROUTE_CONFIG) ||
        (ridx == bridge_pkg::IDX_DECODE_STATUS) ||
        (ridx == bridge_pkg::IDX_DECODE_STATUS + 8'h01);
    assign cfg.prefetch_base_field = base_q;
    assign cfg.prefetch_limit_field = limit_q;
    assign cfg.legacy_video_enable = bc_q[bridge_pkg::BC_LEGACY_VIDEO];
    assign cfg.isa_alias_enable = bc_q[bridge_pkg::BC_ISA_ALIAS];
    assign cfg.mono_display_routing_bit = rc_q[bridge_pkg::RC_MONO];
    assign cfg.io_window_base = iob_q;
    assign cfg.io_window_limit = iol_q;
    assign parity_response_enable = bc_q[bridge_pkg::BC_PARITY_RESP];
    assign bridge_global_error_enable = rc_q[bridge_pkg::RC_GLOBAL_ERR];
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_q <= '0;
            awready <= 1'b1;
            w_q <= 32'h0000_0000;
            ws_q <= 4'h0;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= bridge_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_q <= awaddr;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                w_q <= wdata;
                ws_q <= wstrb;
                wready <= 1'b0;
            end
            if (do_write) begin
                bvalid <= 1'b1;
                bresp <= w_ok ? bridge_pkg::RESP_OKAY : bridge_pkg::RESP_SLVERR;
                awready <= 1'b1;
                wready <= 1'b1;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            base_q <= bridge_pkg::RST_BASE_FIELD;
            limit_q <= bridge_pkg::RST_LIMIT_FIELD;
            bc_q <= bridge_pkg::RST_BRIDGE_CONTROL;
            rc_q <= 2'b00;
            iob_q <= 16'h0000;
            iol_q <= 16'h0000;
        end else begin
            if (w_base && ws_q[1:0] == 2'b11) begin
                base_q <= w_q[15:bridge_pkg::FIELD_LSB];
            end
            if (w_limit && ws_q[1:0] == 2'b11) begin
                limit_q <= w_q[15:bridge_pkg::FIELD_LSB];
            end
            // Read-only bits never take a write
            if (w_bc && ws_q[0]) begin
                bc_q <= w_q[7:0] & bridge_pkg::BC_WRITABLE;
            end
            if (w_rc && ws_q[0]) begin
                rc_q <= w_q[1:0];
            end
            if (w_iob && ws_q[1:0] == 2'b11) begin
                iob_q <= w_q[15:0];
            end
            if (w_iol && ws_q[3:2] == 2'b11) begin
                iol_q <= w_q[31:16];
            end
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
            rdata <= 32'h0000_0000;
            rresp <= bridge_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            arready <= 1'b0;
            rdata <= rd_val;
            rresp <= r_ok ? bridge_pkg::RESP_OKAY : bridge_pkg::RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end
endmodule

// >>> hdl/prefetch_window_bridge_control.sv
// Top: prefetch window decode, legacy routing, abort data handling and parity error reporting
// Summary of operation
// - Base bits 15:4 writable, holding address bits 31:20 of window bottom.
// - Low four bits of base and limit read as zero.
// - Base comparison uses zero for address bits 19:0.
// - Limit bits 15:4 writable, holding address bits 31:20 of window top.
// - Limit comparison uses all ones for address bits 19:0.
// - Memory access between base and limit goes to secondary bus.
// - Back-to-back enable reads zero; never issue back-to-back cycles.
// - Secondary reset bit reads zero; writes never reset secondary bus.
// - Abort mode reads zero; master abort drops writes, reads return ones.
// - Video enable with mono routing bit chooses legacy video destination; the decode here reads only video enable, mono routing bit is unused.
// - Both bits zero: all legacy video goes to hub link.
// - Video enable set: colour to secondary, mono to hub link.
// - Alias enable clear: all in-range I/O goes to secondary bus.
// - Alias enable set: upper 768 bytes per 1 KB go to hub.
// - Error forward enable reads zero; no secondary error pin.
// - Parity response clear: parity errors unreported, other errors still reported.
// - Parity response set: parity errors reported when global error enable set.
`timescale 1ns/1ps
module prefetch_window_bridge_control (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // AXI4-Lite write
    input wire logic [9:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // AXI4-Lite read
    input wire logic [9:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Processor memory request
    input wire logic MEM_REQ,
    input wire logic [31:0] MEM_ADDR,
    input wire logic MEM_LEGACY_COLOR,
    input wire logic MEM_LEGACY_MONO,
    // Processor I/O request
    input wire logic IO_REQ,
    input wire logic [15:0] IO_ADDR,
    // Routing result, one cycle after request
    output logic MEM_TO_SECONDARY,
    output logic MEM_TO_HUB,
    output logic MEM_PREFETCHABLE,
    output logic IO_TO_SECONDARY,
    output logic IO_TO_HUB,
    // Secondary bus master completion
    input wire logic SEC_DONE,
    input wire logic SEC_MASTER_ABORT,
    input wire logic SEC_IS_READ,
    input wire logic [31:0] SEC_RDATA,
    output logic [31:0] CPU_RDATA,
    output logic CPU_RDATA_VALID,
    output logic SEC_WRITE_DROPPED,
    output logic SEC_BACK_TO_BACK,
    output logic SEC_RESET_OUT,
    // Secondary bus errors
    input wire logic SEC_PARITY_ERR,
    input wire logic SEC_OTHER_ERR,
    output logic HUB_SERR_MSG
);
    window_cfg_if cfg ();
    bridge_pkg::route_t mem_route;
    bridge_pkg::route_t io_route;
    logic prefetch_hit;
    logic parity_en;
    logic global_err_en;
    logic report_err;
    logic abort_read;
    logic abort_write;
    logic [7:0] status_word;
    logic mem_sec_q;
    logic mem_hub_q;
    logic mem_pf_q;
    logic io_sec_q;
    logic io_hub_q;
    logic [31:0] rdata_q;
    logic rdata_valid_q;
    logic wdrop_q;
    logic serr_q;
    logic [7:0] status_q;

    axi_regs u_regs (
        .clk(CLK_SYS),
        .rst(RST),
        .cfg(cfg.regs),
        .awaddr(S_AXI_AWADDR),
        .awvalid(S_AXI_AWVALID),
        .awready(S_AXI_AWREADY),
        .wdata(S_AXI_WDATA),
        .wstrb(S_AXI_WSTRB),
        .wvalid(S_AXI_WVALID),
        .wready(S_AXI_WREADY),
        .bresp(S_AXI_BRESP),
        .bvalid(S_AXI_BVALID),
        .bready(S_AXI_BREADY),
        .araddr(S_AXI_ARADDR),
        .arvalid(S_AXI_ARVALID),
        .arready(S_AXI_ARREADY),
        .rdata(S_AXI_RDATA),
        .rresp(S_AXI_RRESP),
        .rvalid(S_AXI_RVALID),
        .rready(S_AXI_RREADY),
        .status_word(status_word),
        .parity_response_enable(parity_en),
        .bridge_global_error_enable(global_err_en)
    );

    window_decode u_dec (
        .cfg(cfg.dec),
        .mem_addr(MEM_ADDR),
        .mem_is_legacy_color(MEM_LEGACY_COLOR),
        .mem_is_legacy_mono(MEM_LEGACY_MONO),
        .io_addr(IO_ADDR),
        .mem_route(mem_route),
        .io_route(io_route),
        .prefetch_hit(prefetch_hit)
    );

    // Parity errors gated by both enables; other errors need only the global enable
    assign report_err = global_err_en &&
        ((SEC_PARITY_ERR && parity_en) || SEC_OTHER_ERR);
    // Abort mode is fixed at zero, so aborts always use the discard behaviour
    assign abort_read = SEC_DONE && SEC_MASTER_ABORT && SEC_IS_READ;
    assign abort_write = SEC_DONE && SEC_MASTER_ABORT && !SEC_IS_READ;
    assign status_word = status_q;

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            mem_sec_q <= 1'b0;
            mem_hub_q <= 1'b0;
            mem_pf_q <= 1'b0;
            io_sec_q <= 1'b0;
            io_hub_q <= 1'b0;
        end else begin
            mem_sec_q <= MEM_REQ && mem_route == bridge_pkg::ROUTE_SECONDARY;
            mem_hub_q <= MEM_REQ && mem_route == bridge_pkg::ROUTE_HUB;
            mem_pf_q <= MEM_REQ && prefetch_hit && mem_route == bridge_pkg::ROUTE_SECONDARY;
            io_sec_q <= IO_REQ && io_route == bridge_pkg::ROUTE_SECONDARY;
            io_hub_q <= IO_REQ && io_route == bridge_pkg::ROUTE_HUB;
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            rdata_q <= 32'h0000_0000;
            rdata_valid_q <= 1'b0;
            wdrop_q <= 1'b0;
            serr_q <= 1'b0;
        end else begin
            rdata_valid_q <= SEC_DONE && SEC_IS_READ;
            if (SEC_DONE && SEC_IS_READ) begin
                rdata_q <= abort_read ? bridge_pkg::ALL_ONES : SEC_RDATA;
            end
            wdrop_q <= abort_write;
            serr_q <= report_err;
        end
    end

    // Status shows the previous cycle's routing flags except MEM_TO_HUB, and the error report; rewritten every clock, not held
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            status_q <= 8'h00;
        end else begin
            status_q <= {3'b000, report_err, mem_pf_q, io_hub_q, io_sec_q, mem_sec_q};
        end
    end

    assign MEM_TO_SECONDARY = mem_sec_q;
    assign MEM_TO_HUB = mem_hub_q;
    assign MEM_PREFETCHABLE = mem_pf_q;
    assign IO_TO_SECONDARY = io_sec_q;
    assign IO_TO_HUB = io_hub_q;
    assign CPU_RDATA = rdata_q;
    assign CPU_RDATA_VALID = rdata_valid_q;
    assign SEC_WRITE_DROPPED = wdrop_q;
    assign HUB_SERR_MSG = serr_q;
    // No back-to-back cycles and no secondary reset are ever produced
    assign SEC_BACK_TO_BACK = 1'b0;
    assign SEC_RESET_OUT = 1'b0;
endmodule

// >>> test/bridge_props.sv
// Checker: routing outputs, abort handling and hardwired outputs of the window bridge
`timescale 1ns/1ps
module bridge_props (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // Requests and completions
    input wire logic MEM_REQ,
    input wire logic MEM_LEGACY_MONO,
    input wire logic SEC_DONE,
    input wire logic SEC_MASTER_ABORT,
    input wire logic SEC_IS_READ,
    input wire logic [31:0] SEC_RDATA,
    // Results
    input wire logic MEM_TO_SECONDARY,
    input wire logic MEM_TO_HUB,
    input wire logic MEM_PREFETCHABLE,
    input wire logic [31:0] CPU_RDATA,
    input wire logic CPU_RDATA_VALID,
    input wire logic SEC_WRITE_DROPPED,
    input wire logic SEC_BACK_TO_BACK,
    input wire logic SEC_RESET_OUT
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    sequence s_abort_rd;
        SEC_DONE && SEC_MASTER_ABORT && SEC_IS_READ;
    endsequence
    sequence s_abort_wr;
        SEC_DONE && SEC_MASTER_ABORT && !SEC_IS_READ;
    endsequence
    a_no_back_to_back: assert property (SEC_BACK_TO_BACK == 1'b0)
        else $error("back to back cycle issued");
    a_no_sec_reset: assert property (SEC_RESET_OUT == 1'b0)
        else $error("secondary reset driven");
    a_abort_read_ones: assert property (s_abort_rd |=> CPU_RDATA_VALID
        && CPU_RDATA == 32'hffff_ffff) else $error("aborted read did not return ones");
    a_abort_write_drop: assert property (s_abort_wr |=> SEC_WRITE_DROPPED
        && !CPU_RDATA_VALID) else $error("aborted write not dropped");
    a_read_data_pass: assert property (SEC_DONE && !SEC_MASTER_ABORT && SEC_IS_READ
        |=> CPU_RDATA == $past(SEC_RDATA)) else $error("read data not passed through");
    a_prefetch_secondary: assert property (MEM_PREFETCHABLE |-> MEM_TO_SECONDARY)
        else $error("prefetchable without secondary route");
    a_mono_to_hub: assert property (MEM_REQ && MEM_LEGACY_MONO
        |=> MEM_TO_HUB && !MEM_TO_SECONDARY) else $error("mono access not routed to hub");
    a_idle_no_route: assert property (!MEM_REQ |=> !MEM_TO_SECONDARY && !MEM_TO_HUB)
        else $error("route without request");
    a_single_dest: assert property (!(MEM_TO_SECONDARY && MEM_TO_HUB))
        else $error("memory access sent two ways");
endmodule
bind prefetch_window_bridge_control bridge_props i_props (.CLK_SYS(CLK_SYS), .RST(RST),
    .MEM_REQ(MEM_REQ), .MEM_LEGACY_MONO(MEM_LEGACY_MONO), .SEC_DONE(SEC_DONE),
    .SEC_MASTER_ABORT(SEC_MASTER_ABORT), .SEC_IS_READ(SEC_IS_READ), .SEC_RDATA(SEC_RDATA),
    .MEM_TO_SECONDARY(MEM_TO_SECONDARY), .MEM_TO_HUB(MEM_TO_HUB),
    .MEM_PREFETCHABLE(MEM_PREFETCHABLE), .CPU_RDATA(CPU_RDATA),
    .CPU_RDATA_VALID(CPU_RDATA_VALID), .SEC_WRITE_DROPPED(SEC_WRITE_DROPPED),
    .SEC_BACK_TO_BACK(SEC_BACK_TO_BACK), .SEC_RESET_OUT(SEC_RESET_OUT));

// >>> test/sec_device_model.sv
// Partner: secondary bus device reporting completions and bus errors
`timescale 1ns/1ps
module sec_device_model (
    // Clock
    input wire logic clk,
    // Completion and errors toward the bridge
    output logic done,
    output logic abort,
    output logic is_read,
    output logic [31:0] rdata,
    output logic par_err,
    output logic oth_err
);
    initial {done, abort, is_read, rdata, par_err, oth_err} = '0;
    // Data turns over once released so a stale word cannot pass for a fresh one
    task automatic finish(input logic rd, input logic ab, input logic [31:0] d, input int stall);
        repeat (stall) @(posedge clk);
        {done, abort, is_read, rdata} <= {1'b1, ab, rd, d};
        @(posedge clk);
        done <= 1'b0;
        rdata <= ~d;
    endtask
    task automatic err(input logic p, input logic o);
        @(posedge clk);
        {par_err, oth_err} <= {p, o};
        @(posedge clk);
        {par_err, oth_err} <= 2'b00;
    endtask
endmodule

// >>> test/tb_top.sv
// Testbench: register map, window and legacy decode, abort handling and error reporting
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [9:0] awa = '0, ara = '0;
    logic [31:0] wd = '0, madr = '0, lrd, rdat, cdat, sdat;
    logic [3:0] ws = 4'h0;
    logic [15:0] iadr = '0;
    logic awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, mreq = 0, mcol = 0, mmono = 0, ireq = 0;
    logic awr, wr_r, bv, arr, rv, m_sec, m_hub, m_pf, io_sec, io_hub, rd_v, drop, serr;
    logic sdone, sab, srd, spar, soth;
    logic [1:0] br, rr, lresp;
    int errors = 0, checked = 0;
    always #50 clk = ~clk;
    prefetch_window_bridge_control i_dut (.CLK_SYS(clk), .RST(rst), .S_AXI_AWADDR(awa),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws),
        .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_r), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
        .S_AXI_BREADY(bre), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre),
        .MEM_REQ(mreq), .MEM_ADDR(madr), .MEM_LEGACY_COLOR(mcol), .MEM_LEGACY_MONO(mmono),
        .IO_REQ(ireq), .IO_ADDR(iadr), .MEM_TO_SECONDARY(m_sec), .MEM_TO_HUB(m_hub),
        .MEM_PREFETCHABLE(m_pf), .IO_TO_SECONDARY(io_sec), .IO_TO_HUB(io_hub),
        .SEC_DONE(sdone), .SEC_MASTER_ABORT(sab), .SEC_IS_READ(srd), .SEC_RDATA(sdat),
        .CPU_RDATA(cdat), .CPU_RDATA_VALID(rd_v), .SEC_WRITE_DROPPED(drop),
        .SEC_BACK_TO_BACK(), .SEC_RESET_OUT(), .SEC_PARITY_ERR(spar), .SEC_OTHER_ERR(soth),
        .HUB_SERR_MSG(serr));
    sec_device_model i_sm (.clk(clk), .done(sdone), .abort(sab), .is_read(srd), .rdata(sdat),
        .par_err(spar), .oth_err(soth));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge clk);
        {awa, wd, ws, awv, wv, bre} <= {a, d, 4'hf, 3'b111};
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr_r) wv <= 1'b0;
        end while (!bv);
        bre <= 1'b0;
        lresp = br;
    endtask
    task automatic rd(input logic [9:0] a);
        @(posedge clk);
        {ara, arv, rre} <= {a, 2'b11};
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        rre <= 1'b0;
        lrd = rdat;
        lresp = rr;
    endtask
    task automatic mem(input logic [31:0] a, input logic c, input logic m);
        @(posedge clk);
        {mreq, mcol, mmono, madr} <= {1'b1, c, m, a};
        @(posedge clk);
        mreq <= 1'b0;
        @(negedge clk);
    endtask
    task automatic io(input logic [15:0] a);
        @(posedge clk);
        {ireq, iadr} <= {1'b1, a};
        @(posedge clk);
        ireq <= 1'b0;
        @(negedge clk);
    endtask
    function automatic logic hit(input logic [31:0] a, input logic [11:0] b, input logic [11:0] l);
        return a >= {b, 20'h0_0000} && a <= {l, 20'hf_ffff};
    endfunction
    // Result {secondary, hub}; I/O window fixed at 0100..0fff
    function automatic logic [1:0] io_exp(input logic [15:0] a, input logic al);
        if (a < 16'h0100 || a > 16'h0fff) return 2'b00;
        return (al && a[9:8] != 2'b00) ? 2'b01 : 2'b10;
    endfunction
    initial begin
        logic [11:0] b, l;
        logic [31:0] d, pts [6];
        logic [15:0] ipts [8];
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        void'($urandom(32'he834_30c4));
        rd(10'h090);
        check("base reset", lrd, 32'h0000_fff0);
        rd(10'h098);
        check("limit reset", lrd, 32'h0000_0000);
        rd(10'h0f8);
        check("control reset", lrd, 32'h0000_0000);
        rd(10'h3fc);
        check("unmapped read resp", lresp, 32'h0000_0002);
        mem(32'hfff0_0000, 1'b0, 1'b0);
        check("unprogrammed window", m_pf, 32'h0000_0000);
        wr(10'h0f8, 32'hffff_ffff);
        rd(10'h0f8);
        check("control read", lrd, 32'h0000_000d);
        wr(10'h3fc, 32'h0000_0001);
        check("unmapped write resp", lresp, 32'h0000_0002);
        $display("test registers done");
        for (int k = 0; k < 4; k++) begin
            b = (k == 0) ? 12'h800 : 12'($urandom);
            l = (k == 0) ? 12'h800 : 12'($urandom);
            if (b > l) {b, l} = {l, b};
            wr(10'h090, {16'h0000, b, 4'hf});
            wr(10'h098, {16'h0000, l, 4'hf});
            rd(10'h090);
            check("base field", lrd, {16'h0000, b, 4'h0});
            rd(10'h098);
            check("limit field", lrd, {16'h0000, l, 4'h0});
            pts = '{{b, 20'h0_0000}, {b, 20'h0_0000} - 32'h1, {l, 20'hf_ffff},
                {l, 20'hf_ffff} + 32'h1, $urandom, {b, 20'h0_0000} + 32'h0_1234};
            foreach (pts[j]) begin
                mem(pts[j], 1'b0, 1'b0);
                check("prefetch hit", m_pf, hit(pts[j], b, l));
                check("window route", m_sec, hit(pts[j], b, l));
            end
        end
        $display("test window done");
        for (int i = 0; i < 3; i++) begin
            wr(10'h0f8, {28'h000_0000, i != 0, 3'b000});
            wr(10'h100, {31'h0000_0000, i == 2});
            d = $urandom;
            mem(d, 1'b1, 1'b0);
            check("colour secondary", m_sec, i != 0);
            check("colour hub", m_hub, i == 0);
            mem(d, 1'b0, 1'b1);
            check("mono hub", {m_sec, m_hub}, 32'h0000_0001);
        end
        $display("test legacy done");
        wr(10'h108, 32'h0fff_0100);
        ipts = '{16'h00ff, 16'h0100, 16'h03ff, 16'h0400, 16'h0500, 16'h0fff, 16'h1000,
            16'($urandom)};
        for (int al = 0; al < 2; al++) begin
            wr(10'h0f8, {29'h0000_0000, al == 1, 2'b00});
            foreach (ipts[j]) begin
                io(ipts[j]);
                check("io dst", {io_sec, io_hub}, io_exp(ipts[j], al == 1));
            end
        end
        $display("test io done");
        for (int i = 0; i < 16; i++) begin
            wr(10'h0f8, {31'h0000_0000, i[0]});
            wr(10'h100, {30'h0000_0000, i[1], 1'b0});
            i_sm.err(i[2], i[3]);
            @(negedge clk);
            check("error message", serr, i[1] & (i[2] & i[0] | i[3]));
        end
        $display("test errors done");
        for (int i = 0; i < 8; i++) begin
            d = $urandom;
            i_sm.finish(i[0], i[1], d, 1 + $urandom % 3);
            @(negedge clk);
            check("read valid", rd_v, i[0]);
            if (i[0]) check("read data", cdat, i[1] ? 32'hffff_ffff : d);
            check("write dropped", drop, i[1] & !i[0]);
        end
        $display("test abort done");
        summarize();
    end
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        summarize();
    end
endmodule
